// ===== logic/isps_pkg.sv
package isps_pkg;

  // ------------------------------------------------------------
  // Sources, in natural order (index 0 wins ties)
  // ------------------------------------------------------------
  localparam int NUM_SRC   = 11;
  localparam int IDX_W     = $clog2(NUM_SRC);
  localparam int LVL_W     = 2;
  localparam int NUM_LVL   = 4;
  localparam int SRC_WDT   = 0;
  localparam int SRC_I2C   = 1;
  localparam int SRC_PIN   = 2;
  localparam int SRC_FB    = 3;
  localparam int SRC_SPI   = 4;
  localparam int SRC_T2    = 5;
  localparam int SRC_CAP   = 6;
  localparam int SRC_PWM   = 7;
  localparam int SRC_UART1 = 8;
  localparam int SRC_T3    = 9;
  localparam int SRC_WKT   = 10;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] EXT_PRIORITY_LOW_ADDR   = 8'hEF;
  localparam logic [7:0] EXT_PRIORITY_HIGH_ADDR  = 8'hF7;
  localparam logic [7:0] EXT2_PRIORITY_LOW_ADDR  = 8'hFE;
  localparam logic [7:0] EXT2_PRIORITY_HIGH_ADDR = 8'hFF;
  localparam logic       EXT2_PAGE               = 1'h0;
  localparam logic [7:0] EXT_PRIORITY_RESET      = 8'h00;
  localparam logic [7:0] EXT2_PRIORITY_RESET     = 8'h00;
  localparam logic [7:0] EXT2_USED_MASK          = 8'h07;
  localparam logic [7:0] UNMAPPED_READ           = 8'h00;

  // ------------------------------------------------------------
  // Field positions (same bit in low and high register)
  // ------------------------------------------------------------
  localparam logic [2:0] TIMER2_PRIO_POS        = 3'h7;
  localparam logic [2:0] SERIAL_PERIPH_PRIO_POS = 3'h6;
  localparam logic [2:0] FAULT_BRAKE_PRIO_POS   = 3'h5;
  localparam logic [2:0] WATCHDOG_PRIO_POS      = 3'h4;
  localparam logic [2:0] PULSE_MOD_PRIO_POS     = 3'h3;
  localparam logic [2:0] CAPTURE_PRIO_POS       = 3'h2;
  localparam logic [2:0] PIN_IRQ_PRIO_POS       = 3'h1;
  localparam logic [2:0] TWO_WIRE_PRIO_POS      = 3'h0;
  localparam logic [2:0] WAKEUP_TIMER_PRIO_POS  = 3'h2;
  localparam logic [2:0] TIMER3_PRIO_POS        = 3'h1;
  localparam logic [2:0] UART1_PRIO_POS         = 3'h0;

  localparam logic [NUM_SRC-1:0][2:0] SRC_BIT_POS = {
    WAKEUP_TIMER_PRIO_POS, TIMER3_PRIO_POS, UART1_PRIO_POS, PULSE_MOD_PRIO_POS,
    CAPTURE_PRIO_POS, TIMER2_PRIO_POS, SERIAL_PERIPH_PRIO_POS, FAULT_BRAKE_PRIO_POS,
    PIN_IRQ_PRIO_POS, TWO_WIRE_PRIO_POS, WATCHDOG_PRIO_POS};

  // Sources whose priority bits live in the second register pair
  localparam logic [NUM_SRC-1:0] SRC_IN_EXT2 = 11'h700;

  // Sources whose flag is cleared by hardware on vectoring
  localparam logic [NUM_SRC-1:0] AUTO_CLEAR_MASK = 11'h200;

  localparam logic [NUM_SRC-1:0][15:0] VECTOR_ADDR = {
    16'h008B, 16'h0083, 16'h007B, 16'h006B, 16'h0063, 16'h002B,
    16'h004B, 16'h0073, 16'h003B, 16'h0033, 16'h0053};

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       page;
  } isps_sfr_type;

  typedef struct packed {
    logic last;
    logic writes_ctrl;
    logic is_return_from_interrupt;
  } isps_instr_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
  } isps_call_type;

endpackage

// ===== logic/isps_resolver.sv
module isps_resolver #(
  parameter int N = isps_pkg::NUM_SRC
) (
  // Requests and priority bits
  input  wire logic [N-1:0]                 pend,
  input  wire logic [N-1:0]                 prio_lo,
  input  wire logic [N-1:0]                 prio_hi,
  // Winner
  output logic                              any,
  output logic [isps_pkg::IDX_W-1:0]        win_idx,
  output logic [isps_pkg::LVL_W-1:0]        win_lvl
);
  import isps_pkg::*;

  logic [N-1:0][LVL_W-1:0] lvl;

  // ------------------------------------------------------------
  // Per-source level
  // ------------------------------------------------------------
  for (genvar s = 0; s < N; s++) begin : g_lvl
    assign lvl[s] = {prio_hi[s], prio_lo[s]}; // [RULE12] [RULE17]
  end

  // ------------------------------------------------------------
  // Highest level, then lowest natural index
  // ------------------------------------------------------------
  always_comb begin
    any     = 1'b0;
    win_idx = '0;
    win_lvl = '0;
    for (int s = N - 1; s >= 0; s--) begin
      if (pend[s] && (!any || lvl[s] >= win_lvl)) begin // [RULE18]
        any     = 1'b1;
        win_idx = IDX_W'(s);
        win_lvl = lvl[s];
      end
    end
  end

endmodule

// ===== logic/isps_ctrl.sv
// Overview of operation
// RULE1: Flags sampled and priority resolved every clock, in the same cycle.
// RULE2: No vector call while equal or higher level routine is in service.
// RULE3: Vector call only on the last cycle of the current instruction.
// RULE4: Writes to enable or priority bits, or interrupt return, block vectoring.
// RULE5: Blocked requests are not remembered; every poll starts fresh.
// RULE6: Core pushes program counter like a subroutine call, status word not saved.
// RULE7: Program counter then loaded with the winning source's fixed vector.
// RULE8: Some sources have their flag cleared on vectoring, others keep it.
// RULE9: Interrupt return pops program counter and ends the current service level.
// RULE10: Core resumes from whatever address is popped, with no check.
// RULE11: Plain return leaves in-service state; routines must end with interrupt return.
// RULE12: Source level combines low bit with same-position bit of high register.
// RULE13: First pair: timer2 7, SPI 6, brake 5, watchdog 4, PWM 3, capture 2, pin 1, I2C 0.
// RULE14: Second pair: wake-up timer 2, timer3 1, uart1 0; bits 7 to 3 unused.
// RULE15: Second pair reachable only while register page 0 is selected.
// RULE16: All priority registers reset to zero, every source at lowest level.
// RULE17: Bit pair high,low gives level 0 to 3, 3 highest.
// RULE18: Equal-level requests resolved by fixed natural source order.
// RULE19: One in-service bit per level so higher levels nest above lower.
module isps_ctrl #(
  parameter int N = isps_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  // Register access from the core
  input  wire isps_pkg::isps_sfr_type    sfr,
  output logic [7:0]                     sfr_rdata,
  // Interrupt sources
  input  wire logic [N-1:0]              irq_flag,
  input  wire logic [N-1:0]              irq_en,
  // Instruction sequencer status
  input  wire isps_pkg::isps_instr_type  instr,
  // Vector call and service state
  output isps_pkg::isps_call_type        call,
  output logic [N-1:0]                   flag_clear,
  output logic [isps_pkg::NUM_LVL-1:0]   in_service
);
  import isps_pkg::*;

  logic [7:0]          ext_lo_r;
  logic [7:0]          ext_lo_nxt;
  logic [7:0]          ext_hi_r;
  logic [7:0]          ext_hi_nxt;
  logic [7:0]          ext2_lo_r;
  logic [7:0]          ext2_lo_nxt;
  logic [7:0]          ext2_hi_r;
  logic [7:0]          ext2_hi_nxt;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                page_ok;
  logic                wr_hit;

  logic [N-1:0]        prio_lo;
  logic [N-1:0]        prio_hi;
  logic [N-1:0]        pend;
  logic                any;
  logic [IDX_W-1:0]    win_idx;
  logic [LVL_W-1:0]    win_lvl;
  logic                svc_any;
  logic [LVL_W-1:0]    svc_top;
  logic                call_go;
  logic                return_from_interrupt_end;

  isps_call_type       call_r;
  isps_call_type       call_nxt;
  logic [N-1:0]        clr_r;
  logic [N-1:0]        clr_nxt;
  logic [NUM_LVL-1:0]  svc_r;
  logic [NUM_LVL-1:0]  svc_nxt;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  assign page_ok = (sfr.page == EXT2_PAGE); // [RULE15]

  always_comb begin
    ext_lo_nxt  = ext_lo_r;
    ext_hi_nxt  = ext_hi_r;
    ext2_lo_nxt = ext2_lo_r;
    ext2_hi_nxt = ext2_hi_r;
    wr_hit      = 1'b0;
    rdata_nxt   = UNMAPPED_READ;
    if (sfr.wr) begin
      unique case (sfr.addr)
        EXT_PRIORITY_LOW_ADDR: begin
          ext_lo_nxt = sfr.wdata; // [RULE13]
          wr_hit     = 1'b1;
        end
        EXT_PRIORITY_HIGH_ADDR: begin
          ext_hi_nxt = sfr.wdata; // [RULE13]
          wr_hit     = 1'b1;
        end
        EXT2_PRIORITY_LOW_ADDR: begin
          if (page_ok) begin
            ext2_lo_nxt = sfr.wdata & EXT2_USED_MASK; // [RULE14]
            wr_hit      = 1'b1;
          end
        end
        EXT2_PRIORITY_HIGH_ADDR: begin
          if (page_ok) begin
            ext2_hi_nxt = sfr.wdata & EXT2_USED_MASK; // [RULE14]
            wr_hit      = 1'b1;
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end
    unique case (sfr.addr)
      EXT_PRIORITY_LOW_ADDR:   rdata_nxt = ext_lo_r;
      EXT_PRIORITY_HIGH_ADDR:  rdata_nxt = ext_hi_r;
      EXT2_PRIORITY_LOW_ADDR:  rdata_nxt = page_ok ? ext2_lo_r : UNMAPPED_READ; // [RULE15]
      EXT2_PRIORITY_HIGH_ADDR: rdata_nxt = page_ok ? ext2_hi_r : UNMAPPED_READ; // [RULE15]
      default:                 rdata_nxt = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_lo_r  <= EXT_PRIORITY_RESET; // [RULE16]
      ext_hi_r  <= EXT_PRIORITY_RESET; // [RULE16]
      ext2_lo_r <= EXT2_PRIORITY_RESET; // [RULE16]
      ext2_hi_r <= EXT2_PRIORITY_RESET; // [RULE16]
      rdata_r   <= UNMAPPED_READ;
    end else if (ce) begin
      ext_lo_r  <= ext_lo_nxt;
      ext_hi_r  <= ext_hi_nxt;
      ext2_lo_r <= ext2_lo_nxt;
      ext2_hi_r <= ext2_hi_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Per-source priority bits and live requests
  // ------------------------------------------------------------
  for (genvar s = 0; s < N; s++) begin : g_src
    assign prio_lo[s] = SRC_IN_EXT2[s] ? ext2_lo_r[SRC_BIT_POS[s]] // [RULE14]
                                       : ext_lo_r[SRC_BIT_POS[s]]; // [RULE13]
    assign prio_hi[s] = SRC_IN_EXT2[s] ? ext2_hi_r[SRC_BIT_POS[s]] // [RULE14]
                                       : ext_hi_r[SRC_BIT_POS[s]]; // [RULE13]
  end

  // Live flags every cycle, nothing held between polls
  assign pend = irq_flag & irq_en; // [RULE1] [RULE5]

  isps_resolver #(
    .N (N)
  ) u_resolver (
    .pend    (pend),
    .prio_lo (prio_lo),
    .prio_hi (prio_hi),
    .any     (any),
    .win_idx (win_idx),
    .win_lvl (win_lvl)
  );

  // ------------------------------------------------------------
  // Vectoring decision
  // ------------------------------------------------------------
  always_comb begin
    svc_any = |svc_r;
    svc_top = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (svc_r[l]) begin
        svc_top = LVL_W'(l);
      end
    end
  end

  // Only the interrupt return ends service, a plain return does not
  assign return_from_interrupt_end = instr.last && instr.is_return_from_interrupt && svc_any; // [RULE9] [RULE11]

  assign call_go = any
                && instr.last // [RULE3]
                && !instr.writes_ctrl && !instr.is_return_from_interrupt && !wr_hit // [RULE4]
                && (!svc_any || win_lvl > svc_top); // [RULE2] [RULE19]

  always_comb begin
    call_nxt = '0;
    clr_nxt  = '0;
    svc_nxt  = svc_r;
    if (call_go) begin
      // Core pushes the return address only; status word is left alone
      call_nxt.valid  = 1'b1; // [RULE6]
      call_nxt.vector = VECTOR_ADDR[win_idx]; // [RULE7]
      clr_nxt[win_idx] = AUTO_CLEAR_MASK[win_idx]; // [RULE8]
      svc_nxt[win_lvl] = 1'b1; // [RULE19]
    end else if (return_from_interrupt_end) begin
      // Popped address is trusted as is
      svc_nxt[svc_top] = 1'b0; // [RULE9] [RULE10]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      call_r <= '0;
      clr_r  <= '0;
      svc_r  <= '0;
    end else if (ce) begin
      call_r <= call_nxt;
      clr_r  <= clr_nxt;
      svc_r  <= svc_nxt;
    end
  end

  assign sfr_rdata  = rdata_r;
  assign call       = call_r;
  assign flag_clear = clr_r;
  assign in_service = svc_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_call_only_last;
    @(posedge ref_clk) disable iff (!nrst)
      ce && !instr.last |=> !call.valid;
  endproperty
  a_call_only_last: assert property (p_call_only_last) // [RULE3]
    else $error("vector call outside last instruction cycle");

  property p_blocked_by_ctrl;
    @(posedge ref_clk) disable iff (!nrst)
      ce && (instr.writes_ctrl || instr.is_return_from_interrupt || wr_hit) |=> !call.valid;
  endproperty
  a_blocked_by_ctrl: assert property (p_blocked_by_ctrl) // [RULE4]
    else $error("vector call during blocking instruction");

  property p_level_above_service;
    @(posedge ref_clk) disable iff (!nrst)
      ce && svc_any && (win_lvl <= svc_top) |=> !call.valid;
  endproperty
  a_level_above_service: assert property (p_level_above_service) // [RULE2]
    else $error("vector call at or below in-service level");

  property p_live_request;
    @(posedge ref_clk) disable iff (!nrst)
      call_go |-> irq_flag[win_idx] && irq_en[win_idx];
  endproperty
  a_live_request: assert property (p_live_request) // [RULE5]
    else $error("vector call without a live enabled flag");

  property p_vector_loaded;
    @(posedge ref_clk) disable iff (!nrst)
      ce && call_go |=> call.valid && call.vector == VECTOR_ADDR[$past(win_idx)];
  endproperty
  a_vector_loaded: assert property (p_vector_loaded) // [RULE7]
    else $error("vector address does not match winning source");

  property p_nest_level;
    @(posedge ref_clk) disable iff (!nrst)
      ce && call_go |=> in_service[$past(win_lvl)] && $countones(in_service) > 0;
  endproperty
  a_nest_level: assert property (p_nest_level) // [RULE19]
    else $error("in-service bit not set for accepted level");

  property p_return_from_interrupt_pops_level;
    @(posedge ref_clk) disable iff (!nrst)
      ce && return_from_interrupt_end |=> $countones(in_service) == $countones($past(in_service)) - 1;
  endproperty
  a_return_from_interrupt_pops_level: assert property (p_return_from_interrupt_pops_level) // [RULE9]
    else $error("interrupt return did not end one service level");

  property p_auto_clear;
    @(posedge ref_clk) disable iff (!nrst)
      ce && call_go |=> flag_clear[$past(win_idx)] == AUTO_CLEAR_MASK[$past(win_idx)];
  endproperty
  a_auto_clear: assert property (p_auto_clear) // [RULE8]
    else $error("flag clear does not follow source policy");

  property p_page_guard;
    @(posedge ref_clk) disable iff (!nrst)
      ce && sfr.wr && !page_ok |=> $stable(ext2_lo_r) && $stable(ext2_hi_r);
  endproperty
  a_page_guard: assert property (p_page_guard) // [RULE15]
    else $error("second priority pair written outside page 0");

  property p_winner_level;
    @(posedge ref_clk) disable iff (!nrst)
      call_go |-> win_lvl == {prio_hi[win_idx], prio_lo[win_idx]};
  endproperty
  a_winner_level: assert property (p_winner_level) // [RULE12]
    else $error("winner level not formed from its bit pair");

  property p_plain_return;
    @(posedge ref_clk) disable iff (!nrst)
      ce && instr.last && !instr.is_return_from_interrupt && !call_go |=> $stable(in_service);
  endproperty
  a_plain_return: assert property (p_plain_return) // [RULE11]
    else $error("in-service state changed without a call or interrupt return");

  property p_clear_with_call;
    @(posedge ref_clk) disable iff (!nrst)
      (flag_clear != '0) |-> call.valid;
  endproperty
  a_clear_with_call: assert property (p_clear_with_call) // [RULE8]
    else $error("flag clear without a vector call");

  property p_ext2_unused_zero;
    @(posedge ref_clk) disable iff (!nrst)
      ((ext2_lo_r | ext2_hi_r) & ~EXT2_USED_MASK) == 8'h00;
  endproperty
  a_ext2_unused_zero: assert property (p_ext2_unused_zero) // [RULE14]
    else $error("unused bits of second priority pair set");

endmodule

// ===== test/isps_core_model.sv
module isps_core_model
  import isps_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           nrst,
  // Controller and sequencer status
  input  wire isps_call_type  call,
  input  wire isps_instr_type instr,
  // Program counter view
  output logic [15:0]         pc,
  output logic [15:0]         top
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Return stack
  // ----------------------------------------
  logic [15:0] stack_r [8];
  logic [2:0]  sp_r;

  assign top = stack_r[sp_r - 3'h1];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc   <= 16'h0100;
      sp_r <= 3'h0;
    end else if (call.valid) begin
      // Push like a subroutine call, status word left alone
      stack_r[sp_r] <= pc;
      sp_r          <= sp_r + 3'h1;
      pc            <= call.vector;
    end else if (instr.last && instr.is_return_from_interrupt && sp_r != 3'h0) begin
      // Resume from whatever sits on top, unchecked
      pc   <= stack_r[sp_r - 3'h1];
      sp_r <= sp_r - 3'h1;
    end
  end
endmodule

// ===== test/interrupt_priority_service_test.sv
module interrupt_priority_service_test;
  timeunit 1ns;
  timeprecision 1ns;
  import isps_pkg::*;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic           ref_clk    = 1'h0;
  logic           nrst       = 1'h0;
  isps_sfr_type   sfr        = '0;
  isps_instr_type instr      = '0;
  logic [10:0]    irq_flag   = '0;
  logic [10:0]    irq_en     = 11'h7FF;
  logic           ce         = 1'h1;
  logic [7:0]     sfr_rdata;
  isps_call_type  call;
  logic [10:0]    flag_clear;
  logic [3:0]     in_service;
  logic [15:0]    pc;
  logic [15:0]    top;
  int             n_errors   = 0;
  int             n_compared = 0;

  always #50 ref_clk = ~ref_clk;

  isps_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .irq_flag(irq_flag), .irq_en(irq_en), .instr(instr), .call(call),
    .flag_clear(flag_clear), .in_service(in_service));

  isps_core_model core (.ref_clk(ref_clk), .nrst(nrst), .call(call), .instr(instr),
    .pc(pc), .top(top));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic pg, input logic [7:0] d);
    @(posedge ref_clk);
    sfr <= '{addr: a, wr: 1'h1, wdata: d, page: pg};
    @(posedge ref_clk);
    sfr <= '{addr: a, wr: 1'h0, wdata: d, page: pg};
  endtask

  task automatic rd(input logic [7:0] a, input logic pg, output logic [7:0] d);
    @(posedge ref_clk);
    sfr <= '{addr: a, wr: 1'h0, wdata: 8'h00, page: pg};
    @(posedge ref_clk);
    #1 d = sfr_rdata;
  endtask

  // Flags and {last, writes_ctrl, is_return_from_interrupt} for one cycle; vec 0 means no call
  task automatic poll(input logic [10:0] f, input logic [2:0] ins, input logic [15:0] vec,
                      input logic [3:0] isv);
    @(posedge ref_clk);
    irq_flag <= f;
    instr    <= ins;
    @(posedge ref_clk);
    irq_flag <= '0;
    instr    <= '0;
    #1;
    check("call valid", 16'(call.valid), 16'(vec != 16'h0000));
    check("call vector", call.vector, vec);
    check("in service", 16'(in_service), 16'(isv));
    check("flag clear", 16'(flag_clear), (vec == 16'h0083) ? 16'h0200 : 16'h0000);
  endtask

  task automatic check_pc(input logic [15:0] exp);
    @(posedge ref_clk);
    #1;
    check("program counter", pc, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0]      d;
    logic [3:0][7:0] adr;
    adr = {EXT2_PRIORITY_HIGH_ADDR, EXT2_PRIORITY_LOW_ADDR,
           EXT_PRIORITY_HIGH_ADDR, EXT_PRIORITY_LOW_ADDR};
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], 1'h0, d);
      check("reset value", 16'(d), 16'h0000);
      wr(adr[i], 1'h0, 8'hFF);
      rd(adr[i], 1'h0, d);
      check("readback", 16'(d), (i < 2) ? 16'h00FF : 16'h0007);
      wr(adr[i], 1'h0, 8'h00);
    end
    wr(EXT2_PRIORITY_LOW_ADDR, 1'h1, 8'h05);
    rd(EXT2_PRIORITY_LOW_ADDR, 1'h1, d);
    check("other page read", 16'(d), 16'h0000);
    rd(EXT2_PRIORITY_LOW_ADDR, 1'h0, d);
    check("other page write", 16'(d), 16'h0000);
    rd(8'h10, 1'h0, d);
    check("unmapped read", 16'(d), 16'h0000);
  endtask

  task automatic t_call;
    poll(11'h200, 3'b000, 16'h0000, 4'h0);
    @(posedge ref_clk);
    irq_en <= 11'h5FF;
    poll(11'h200, 3'b100, 16'h0000, 4'h0);
    @(posedge ref_clk);
    irq_en <= 11'h7FF;
    poll(11'h200, 3'b110, 16'h0000, 4'h0);
    poll(11'h000, 3'b100, 16'h0000, 4'h0);
    poll(11'h200, 3'b101, 16'h0000, 4'h0);
    poll(11'h200, 3'b100, 16'h0083, 4'h1);
    check_pc(16'h0083);
    check("stacked return", top, 16'h0100);
    poll(11'h200, 3'b100, 16'h0000, 4'h1);
    poll(11'h000, 3'b100, 16'h0000, 4'h1);
    poll(11'h000, 3'b101, 16'h0000, 4'h0);
    check_pc(16'h0100);
  endtask

  task automatic t_prio;
    wr(EXT_PRIORITY_LOW_ADDR, 1'h0, 8'h90);
    wr(EXT_PRIORITY_HIGH_ADDR, 1'h0, 8'hC0);
    wr(EXT2_PRIORITY_LOW_ADDR, 1'h0, 8'h01);
    poll(11'h101, 3'b100, 16'h0053, 4'h2);
    poll(11'h010, 3'b100, 16'h004B, 4'h6);
    poll(11'h001, 3'b100, 16'h0000, 4'h6);
    poll(11'h020, 3'b100, 16'h002B, 4'hE);
    poll(11'h000, 3'b101, 16'h0000, 4'h6);
    poll(11'h000, 3'b101, 16'h0000, 4'h2);
    poll(11'h000, 3'b101, 16'h0000, 4'h0);
    check_pc(16'h0100);
  endtask

  task automatic t_reset;
    logic [7:0] d;
    poll(11'h001, 3'b100, 16'h0053, 4'h2);
    @(posedge ref_clk);
    nrst <= 1'h0;
    @(posedge ref_clk);
    #1;
    check("call in reset", 16'(call.valid), 16'h0000);
    check("service in reset", 16'(in_service), 16'h0000);
    @(posedge ref_clk);
    nrst <= 1'h1;
    poll(11'h001, 3'b100, 16'h0053, 4'h1);
    poll(11'h000, 3'b101, 16'h0000, 4'h0);
    check_pc(16'h0100);
    rd(EXT_PRIORITY_HIGH_ADDR, 1'h0, d);
    check("reset value again", 16'(d), 16'h0000);
  endtask

  task automatic t_hold;
    logic [7:0] d;
    @(posedge ref_clk);
    ce <= 1'h0;
    wr(EXT_PRIORITY_LOW_ADDR, 1'h0, 8'hFF);
    poll(11'h001, 3'b100, 16'h0000, 4'h0);
    @(posedge ref_clk);
    ce <= 1'h1;
    rd(EXT_PRIORITY_LOW_ADDR, 1'h0, d);
    check("frozen write", 16'(d), 16'h0000);
    @(posedge ref_clk);
    sfr <= '{addr: EXT_PRIORITY_LOW_ADDR, wr: 1'h1, wdata: 8'h00, page: 1'h0};
    poll(11'h001, 3'b100, 16'h0000, 4'h0);
    @(posedge ref_clk);
    sfr <= '{addr: EXT_PRIORITY_LOW_ADDR, wr: 1'h0, wdata: 8'h00, page: 1'h0};
    poll(11'h001, 3'b100, 16'h0053, 4'h1);
    poll(11'h000, 3'b101, 16'h0000, 4'h0);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic conclude;
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'h1;
    t_regs;
    t_call;
    t_prio;
    t_reset;
    t_hold;
    conclude;
  end

  initial begin
    #200000;
    n_errors++;
    conclude;
  end
endmodule
